// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
	import ttse_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic trig_wr_en = 1'b0;
	logic [IDX_W-1:0] trig_wr_addr = '0;
	logic [ELEM_W-1:0] trig_wr_data = '0;
	logic time_master = 1'b1;
	logic event_sync = 1'b0;
	logic ref_go = 1'b0;
	logic [1:0] sync_state = 2'h0;
	logic [1:0] err_in = 2'h0;
	logic [31:0] tx_pending = '0;
	logic tx_done = 1'b0;
	logic rx_accept = 1'b0;
	logic [MNR_W-1:0] rx_filter = '0;
	logic ntu_tick, bit_sample, sof_sample, ref_msg_ok;
	logic [CNT_W-1:0] ref_cycle_count;
	logic [15:0] cycle_time, sync_mark, ref_mark;
	logic tx_prep, window_start, tx_start, tx_clear_pending, ref_tx_req, ref_tx_start;
	logic [TXBUF_W-1:0] tx_prep_buf, tx_buf, tx_clear_buf;
	logic watch_fired, rx_check, rx_check_ok, event_int, event_ext, event_asc, config_error;
	logic tx_arbitrating, rx_filter_kind;
	logic [1:0] error_level_field;
	logic [8:0] obs;
	int error_cnt = 0;
	int check_count = 0;

	always #2 clock = ~clock;
	assign obs = {ref_msg_ok, config_error, event_int, rx_check, watch_fired, ref_tx_start,
		tx_clear_pending, window_start, tx_prep};

	ttse_engine uut (.clock(clock), .srst(srst), .trig_wr_en(trig_wr_en),
		.trig_wr_addr(trig_wr_addr), .trig_wr_data(trig_wr_data), .ntu_tick(ntu_tick),
		.bit_sample(bit_sample), .sof_sample(sof_sample), .ref_msg_ok(ref_msg_ok),
		.ref_cycle_count(ref_cycle_count), .time_master(time_master), .backup_master(1'b0),
		.compete_master(1'b0), .ref_mark_decrement(16'h0000), .initial_ref_trigger_offset(7'h00),
		.event_sync_mode(event_sync), .sync_state_field(sync_state), .error_level_in(err_in),
		.ref_msg_len(16'h0004), .tx_pending(tx_pending), .tx_done(tx_done),
		.rx_accept(rx_accept), .rx_accept_filter(rx_filter), .cycle_time(cycle_time),
		.sync_mark(sync_mark), .ref_mark(ref_mark), .tx_prep(tx_prep), .tx_prep_buf(tx_prep_buf),
		.window_start(window_start), .tx_start(tx_start), .tx_buf(tx_buf),
		.tx_arbitrating(tx_arbitrating),
		.tx_clear_pending(tx_clear_pending), .tx_clear_buf(tx_clear_buf),
		.ref_tx_req(ref_tx_req), .ref_tx_start(ref_tx_start), .watch_fired(watch_fired),
		.rx_check(rx_check), .rx_check_ok(rx_check_ok), .rx_filter_kind(rx_filter_kind),
		.event_int(event_int), .event_ext(event_ext), .event_asc(event_asc),
		.config_error(config_error), .error_level_field(error_level_field));

	ttse_bus_node node (.clock(clock), .srst(srst), .ref_go(ref_go),
		.ref_tx_start(ref_tx_start), .ntu_tick(ntu_tick), .bit_sample(bit_sample),
		.sof_sample(sof_sample), .ref_msg_ok(ref_msg_ok), .ref_cycle_count(ref_cycle_count));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wait_sig(input int sel, input int limit);
		int n;
		n = 0;
		while (obs[sel] !== 1'b1) begin
			@(negedge clock);
			n++;
			if (n > limit) begin
				error_cnt++;
				$display("FAIL wait %0d expected 1 seen 0", sel);
				complete_run();
			end
		end
	endtask : wait_sig

	task automatic rst;
		@(negedge clock);
		srst = 1'b1;
		repeat (2) @(negedge clock);
		srst = 1'b0;
	endtask : rst

	// One element per call; callers keep marks ascending from word 0
	task automatic wr(input logic [5:0] a, input logic [3:0] ty, input logic [15:0] tm,
		input logic [6:0] message_number_field, input logic [2:0] ev);
		logic ign;
		ign = (ty inside {TY_REF, TY_REF_GAP, TY_WATCH, TY_WATCH_GAP}) || ty >= 4'ha;
		@(negedge clock);
		trig_wr_en = 1'b1;
		trig_wr_addr = a;
		// Junk number and zero code on types that ignore them
		trig_wr_data = {ev, 3'h0, ign ? 7'h7f : message_number_field, ty == TY_RX, ty, ign ? 7'h00 : 7'h01, tm};
		@(negedge clock);
		trig_wr_en = 1'b0;
	endtask : wr

	task automatic start_cycle;
		@(negedge clock);
		ref_go = 1'b1;
		@(negedge clock);
		ref_go = 1'b0;
		wait_sig(8, 20);
	endtask : start_cycle

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		err_in = EL_SEV2;
		rst();
		chk("cycle_time", cycle_time, 16'h0000);
		chk("config_error", config_error, 1'b0);
		@(negedge clock);
		chk("level_pass", error_level_field, EL_SEV2);
		err_in = 2'h0;
	endtask : t_reset

	task automatic t_tx(input logic [3:0] ty, input logic [31:0] pend);
		rst();
		tx_pending = pend;
		wr(6'h00, ty, 16'h0010, 7'h03, 3'h0);
		wr(6'h01, TY_REF, 16'h0030, 7'h00, 3'h0);
		wr(6'h02, TY_WATCH, 16'h0040, 7'h00, 3'h0);
		wr(6'h03, 4'ha, 16'h0000, 7'h00, 3'h0);
		start_cycle();
		wait_sig(0, 10);
		chk("tx_prep_buf", tx_prep_buf, 5'h03);
		wait_sig(1, 100);
		chk("window_time", cycle_time >= 16'h0010 && cycle_time <= 16'h0011, 1'b1);
		chk("tx_start", tx_start, pend[3]);
		chk("tx_arb", tx_arbitrating, ty == TY_TX_ARB || ty == TY_TX_MERGED);
		if (pend[3]) begin
			chk("tx_buf", tx_buf, 5'h03);
			@(negedge clock);
			tx_done = 1'b1;
			@(negedge clock);
			tx_done = 1'b0;
			// Clear pulse stands for the one cycle after the done edge
			chk("clear", tx_clear_pending, ty == TY_TX_SINGLE);
			if (ty == TY_TX_SINGLE) begin
				chk("clear_buf", tx_clear_buf, 5'h03);
			end
		end
	endtask : t_tx

	task automatic t_ref(input logic gap, input logic sev2);
		logic [15:0] mk;
		rst();
		mk = 16'h0014 + (sev2 ? REF_SEV2_OFFSET : 16'h0000);
		event_sync = gap;
		sync_state = gap ? SYS_IN_GAP : 2'h0;
		err_in = sev2 ? EL_SEV2 : 2'h0;
		// Variant of the other mode comes first and must be skipped
		wr(6'h00, gap ? TY_REF : TY_REF_GAP, 16'h0010, 7'h00, 3'h0);
		wr(6'h01, gap ? TY_REF_GAP : TY_REF, 16'h0014, 7'h00, 3'h0);
		wr(6'h02, TY_WATCH, 16'h0080, 7'h00, 3'h0);
		wr(6'h03, TY_WATCH_GAP, 16'h0080, 7'h00, 3'h0);
		wr(6'h04, 4'hf, 16'h0000, 7'h00, 3'h0);
		start_cycle();
		wait_sig(3, 1000);
		chk("ref_time", cycle_time >= mk && cycle_time <= mk + 16'h0003, 1'b1);
		chk("ref_req_drop", ref_tx_req, 1'b0);
		@(negedge clock);
		wait_sig(8, 20);
		// Mark and cycle time are taken at the edge after the success pulse
		@(negedge clock);
		chk("ref_mark", ref_mark, sync_mark);
		chk("restart", cycle_time <= 16'h0004, 1'b1);
		chk("watch_quiet", watch_fired, 1'b0);
		event_sync = 1'b0;
		sync_state = 2'h0;
		err_in = 2'h0;
	endtask : t_ref

	task automatic t_watch;
		rst();
		time_master = 1'b0;
		wr(6'h00, TY_WATCH, 16'h0018, 7'h00, 3'h0);
		wr(6'h01, 4'ha, 16'h0000, 7'h00, 3'h0);
		start_cycle();
		wait_sig(4, 200);
		chk("watch_time", cycle_time >= 16'h0018 && cycle_time <= 16'h0019, 1'b1);
		time_master = 1'b1;
	endtask : t_watch

	task automatic t_event;
		rst();
		wr(6'h00, TY_TIMEBASE, 16'h0010, 7'h00, 3'b101);
		wr(6'h01, TY_REF, 16'h0030, 7'h00, 3'h0);
		wr(6'h02, TY_WATCH, 16'h0040, 7'h00, 3'h0);
		wr(6'h03, 4'ha, 16'h0000, 7'h00, 3'h0);
		start_cycle();
		wait_sig(6, 100);
		chk("event_asc", event_asc, 1'b1);
		chk("event_ext", event_ext, 1'b0);
	endtask : t_event

	task automatic t_rx;
		rst();
		sync_state = SYS_IN_SCHED;
		wr(6'h00, TY_RX, 16'h0010, 7'h05, 3'h0);
		wr(6'h01, TY_RX, 16'h0018, 7'h05, 3'h0);
		wr(6'h02, TY_REF, 16'h0030, 7'h00, 3'h0);
		wr(6'h03, TY_WATCH, 16'h0040, 7'h00, 3'h0);
		wr(6'h04, 4'ha, 16'h0000, 7'h00, 3'h0);
		start_cycle();
		rx_accept = 1'b1;
		rx_filter = 7'h05;
		@(negedge clock);
		rx_accept = 1'b0;
		wait_sig(5, 100);
		chk("rx_ok", rx_check_ok, 1'b1);
		chk("rx_kind", rx_filter_kind, 1'b1);
		@(negedge clock);
		wait_sig(5, 100);
		chk("rx_none", rx_check_ok, 1'b0);
		sync_state = 2'h0;
	endtask : t_rx

	task automatic t_err(input logic [3:0] ty0, input logic [3:0] ty1, input logic [15:0] tm0,
		input logic master);
		rst();
		time_master = master;
		tx_pending = 32'hffff_ffff;
		wr(6'h00, ty0, tm0, 7'h01, 3'h0);
		wr(6'h01, ty1, 16'h0030, 7'h02, 3'h0);
		wr(6'h02, TY_WATCH, 16'h0040, 7'h00, 3'h0);
		wr(6'h03, 4'ha, 16'h0000, 7'h00, 3'h0);
		start_cycle();
		wait_sig(7, 200);
		@(negedge clock);
		chk("error_level", error_level_field, EL_SEV3);
		time_master = 1'b1;
	endtask : t_err

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		t_reset();
		for (int t = 2; t <= 5; t++) begin
			t_tx(t[3:0], 32'h0000_0008);
		end
		t_tx(TY_TX_SINGLE, 32'h0000_0000);
		t_ref(1'b0, 1'b0);
		t_ref(1'b1, 1'b0);
		t_ref(1'b0, 1'b1);
		t_watch();
		t_event();
		t_rx();
		t_err(TY_REF, TY_WATCH, 16'h0014, 1'b0);
		t_err(TY_TX_SINGLE, TY_REF, 16'h0002, 1'b1);
		t_err(TY_TX_MERGED, TY_TX_CONT, 16'h0010, 1'b1);
		for (int t = 10; t <= 15; t++) begin
			t_err(t[3:0], TY_REF, 16'h0010, 1'b1);
		end
		complete_run();
	end
endmodule : tb

// ==== ttse_bus_node.sv ====
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Far-side bus node model
// ---------------------------------------------------------------
module ttse_bus_node (
	input wire logic clock,
	input wire logic srst,
	input wire logic ref_go,
	input wire logic ref_tx_start,
	output logic ntu_tick,
	output logic bit_sample,
	output logic sof_sample,
	output logic ref_msg_ok,
	output logic [5:0] ref_cycle_count
);
	logic [1:0] div_q;
	logic [3:0] step_q;
	logic busy_q;
	logic [5:0] cyc_q;

	// Time unit every 2 clocks, bit sample point every 4
	always_ff @(posedge clock) begin
		if (srst) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
	assign ntu_tick = div_q[0];
	assign bit_sample = (div_q == 2'h3);

	// Reference frame: start-of-frame sample, then success with cycle count
	always_ff @(posedge clock) begin
		sof_sample <= 1'b0;
		ref_msg_ok <= 1'b0;
		if (srst) begin
			busy_q <= 1'b0;
			step_q <= 4'h0;
			cyc_q <= 6'h00;
			ref_cycle_count <= 6'h00;
		end else if (!busy_q) begin
			busy_q <= ref_go | ref_tx_start; // Frame begins once request acted on
			step_q <= 4'h0;
		end else begin
			step_q <= step_q + 4'h1;
			sof_sample <= (step_q == 4'h1); // Cycle time origin
			if (step_q == 4'h7) begin
				ref_msg_ok <= 1'b1; // Success comes after start-of-frame
				ref_cycle_count <= cyc_q;
				cyc_q <= cyc_q + 6'h01;
				busy_q <= 1'b0;
			end
		end
	end
endmodule : ttse_bus_node

// ==== ttse_cc_if.sv ====
`timescale 1ns/1ns
// Cycle code against cycle count
interface ttse_cc_if;
	logic [6:0] cycle_code;
	logic [5:0] cycle_count;
	logic match;
	modport eng (output cycle_code, output cycle_count, input match);
	modport dec (input cycle_code, input cycle_count, output match);
endinterface : ttse_cc_if

// ==== ttse_cc_match.sv ====
`timescale 1ns/1ns
module ttse_cc_match (
	ttse_cc_if.dec cc
);
	import ttse_pkg::*;
	logic [CC_W-1:0] mask;
	logic found;
	// ---------------------------------------------------------------
	// Repeat factor from top one, base cycle from bits below
	// ---------------------------------------------------------------
	always_comb begin
		mask = 7'h00;
		found = 1'b0;
		for (int i = CC_W - 1; i >= 0; i--) begin
			if (!found && cc.cycle_code[i]) begin
				found = 1'b1;
				mask = 7'((7'h01 << i) - 7'h01);
			end
		end
		cc.match = found && (({1'b0, cc.cycle_count} & mask) == (cc.cycle_code & mask));
	end
endmodule : ttse_cc_match

// ==== ttse_engine.sv ====
`timescale 1ns/1ns
module ttse_engine (
	input wire logic clock,
	input wire logic srst,
	input wire logic trig_wr_en,
	input wire logic [ttse_pkg::IDX_W-1:0] trig_wr_addr,
	input wire logic [ttse_pkg::ELEM_W-1:0] trig_wr_data,
	input wire logic ntu_tick,
	input wire logic bit_sample,
	input wire logic sof_sample,
	input wire logic ref_msg_ok,
	input wire logic [ttse_pkg::CNT_W-1:0] ref_cycle_count,
	input wire logic time_master,
	input wire logic backup_master,
	input wire logic compete_master,
	input wire logic [15:0] ref_mark_decrement,
	input wire logic [ttse_pkg::IRTO_W-1:0] initial_ref_trigger_offset,
	input wire logic event_sync_mode,
	input wire logic [1:0] sync_state_field,
	input wire logic [1:0] error_level_in,
	input wire logic [15:0] ref_msg_len,
	input wire logic [31:0] tx_pending,
	input wire logic tx_done,
	input wire logic rx_accept,
	input wire logic [ttse_pkg::MNR_W-1:0] rx_accept_filter,
	output logic [15:0] cycle_time,
	output logic [15:0] sync_mark,
	output logic [15:0] ref_mark,
	output logic tx_prep,
	output logic [ttse_pkg::TXBUF_W-1:0] tx_prep_buf,
	output logic window_start,
	output logic tx_start,
	output logic [ttse_pkg::TXBUF_W-1:0] tx_buf,
	output logic tx_arbitrating,
	output logic tx_clear_pending,
	output logic [ttse_pkg::TXBUF_W-1:0] tx_clear_buf,
	output logic ref_tx_req,
	output logic ref_tx_start,
	output logic watch_fired,
	output logic rx_check,
	output logic rx_check_ok,
	output logic rx_filter_kind,
	output logic event_int,
	output logic event_ext,
	output logic event_asc,
	output logic config_error,
	output logic [1:0] error_level_field
);
	import ttse_pkg::*;
	// ---------------------------------------------------------------
	// Trigger store and state
	// ---------------------------------------------------------------
	logic [ELEM_W-1:0] trig_mem [TRIG_DEPTH];
	logic [ELEM_W-1:0] elem_q;
	logic [IDX_W-1:0] idx_q;
	ttse_state_t state_q;
	logic [15:0] local_time_q, cycle_time_q, sync_mark_q, ref_mark_q;
	logic [CNT_W-1:0] cycle_count_q;
	logic prev_merged_q, cfg_err_q, ref_req_q;
	logic last_rx_valid_q;
	logic [MNR_W-1:0] last_rx_filter_q;
	logic active_single_q;
	logic [TXBUF_W-1:0] active_buf_q;
	logic [3:0] ty;
	logic [TM_W-1:0] tm, eff_tm;
	logic [MNR_W-1:0] message_number_field;
	logic is_ref, is_tx, gap_mode, eval_use, eval_err, act, terminal;
	ttse_cc_if cc ();

	ttse_cc_match u_cc (
		.cc (cc)
	);

	assign ty = elem_q[TYPE_LSB +: 4];
	assign tm = elem_q[TM_LSB +: TM_W];
	assign message_number_field = elem_q[MNR_LSB +: MNR_W];
	assign is_ref = (ty == TY_REF) || (ty == TY_REF_GAP);
	assign is_tx = (ty >= TY_TX_SINGLE) && (ty <= TY_TX_MERGED);
	assign gap_mode = event_sync_mode && (sync_state_field == SYS_IN_GAP);
	assign cc.cycle_code = elem_q[CC_LSB +: CC_W];
	assign cc.cycle_count = cycle_count_q;
	assign act = (state_q == ST_WAIT) && (cycle_time_q == eff_tm);
	assign terminal = is_ref || (ty == TY_WATCH) || (ty == TY_WATCH_GAP);

	// Host writes sorted list
	always_ff @(posedge clock) begin
		if (trig_wr_en) begin
			trig_mem[trig_wr_addr] <= trig_wr_data;
		end
	end

	// ---------------------------------------------------------------
	// Time base
	// ---------------------------------------------------------------
	// Free local time and sync mark capture
	always_ff @(posedge clock) begin
		if (srst) begin
			local_time_q <= TIME_RST;
			sync_mark_q <= TIME_RST;
			ref_mark_q <= TIME_RST;
			cycle_count_q <= '0;
		end else begin
			if (ntu_tick) local_time_q <= local_time_q + 16'h0001;
			if (sof_sample) sync_mark_q <= local_time_q;
			if (ref_msg_ok) begin
				ref_mark_q <= sync_mark_q;
				cycle_count_q <= ref_cycle_count;
			end
		end
	end

	// Cycle time restarts from the start-of-frame point
	always_ff @(posedge clock) begin
		if (srst) begin
			cycle_time_q <= TIME_RST;
		end else if (ref_msg_ok) begin
			cycle_time_q <= local_time_q - sync_mark_q + {15'h0000, ntu_tick};
		end else if (ntu_tick) begin
			cycle_time_q <= cycle_time_q + 16'h0001;
		end
	end

	// Effective mark of reference triggers
	always_comb begin
		eff_tm = tm;
		if (is_ref) begin
			if (error_level_in == EL_SEV2) begin
				eff_tm = tm + REF_SEV2_OFFSET;
			end else if (backup_master) begin
				eff_tm = tm + {9'h000, initial_ref_trigger_offset};
			end
			if (compete_master) eff_tm = eff_tm - ref_mark_decrement;
		end
	end

	// ---------------------------------------------------------------
	// Element evaluation
	// ---------------------------------------------------------------
	always_comb begin
		eval_use = 1'b0;
		eval_err = 1'b0;
		case (ty)
			TY_REF, TY_REF_GAP: begin
				eval_err = !time_master;
				eval_use = time_master && ((ty == TY_REF_GAP) == gap_mode);
			end
			TY_WATCH, TY_WATCH_GAP: begin
				eval_use = (ty == TY_WATCH_GAP) == gap_mode;
			end
			TY_TX_SINGLE, TY_TX_CONT: begin
				eval_use = cc.match;
				eval_err = cc.match && prev_merged_q;
			end
			TY_TX_ARB, TY_TX_MERGED, TY_TIMEBASE: begin
				eval_use = cc.match;
			end
			TY_RX: begin
				eval_use = cc.match && ((sync_state_field == SYS_IN_SCHED) ||
					(sync_state_field == SYS_IN_GAP));
			end
			default: begin
				eval_err = 1'b1;
			end
		endcase
		if (eval_use && ((tm < ref_msg_len) || (eff_tm < cycle_time_q))) begin
			eval_err = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Frame synchronisation engine
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= ST_IDLE;
			idx_q <= IDX_FIRST;
			elem_q <= '0;
		end else if (ref_msg_ok && (state_q != ST_HALT)) begin
			state_q <= ST_FETCH;
			idx_q <= IDX_FIRST;
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_q <= ST_IDLE;
				end
				ST_FETCH: begin
					elem_q <= trig_mem[idx_q];
					state_q <= ST_EVAL;
				end
				ST_EVAL: begin
					if (eval_err) begin
						state_q <= ST_HALT;
					end else if (eval_use) begin
						state_q <= ST_WAIT;
					end else if (idx_q == IDX_LAST) begin
						state_q <= ST_HALT;
					end else begin
						idx_q <= idx_q + 6'h01;
						state_q <= ST_FETCH;
					end
				end
				ST_WAIT: begin
					if (act && terminal) begin
						state_q <= ST_IDLE;
					end else if (act && (idx_q == IDX_LAST)) begin
						state_q <= ST_HALT;
					end else if (act) begin
						idx_q <= idx_q + 6'h01;
						state_q <= ST_FETCH;
					end
				end
				ST_HALT: begin
					state_q <= ST_HALT;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Sticky configuration error
	always_ff @(posedge clock) begin
		if (srst) begin
			cfg_err_q <= 1'b0;
			error_level_field <= 2'h0;
		end else begin
			if (((state_q == ST_EVAL) && (eval_err || (!eval_use && idx_q == IDX_LAST))) ||
				(act && !terminal && idx_q == IDX_LAST)) begin
				cfg_err_q <= 1'b1;
			end
			error_level_field <= cfg_err_q ? EL_SEV3 : error_level_in;
		end
	end

	// ---------------------------------------------------------------
	// Trigger actions
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			tx_prep <= 1'b0;
			tx_prep_buf <= '0;
			window_start <= 1'b0;
			tx_start <= 1'b0;
			tx_buf <= '0;
			tx_arbitrating <= 1'b0;
			watch_fired <= 1'b0;
			event_int <= 1'b0;
			event_ext <= 1'b0;
			event_asc <= 1'b0;
			prev_merged_q <= 1'b0;
		end else begin
			tx_prep <= (state_q == ST_EVAL) && !eval_err && eval_use && is_tx;
			if ((state_q == ST_EVAL) && is_tx) tx_prep_buf <= message_number_field[TXBUF_W-1:0];
			window_start <= act && is_tx;
			tx_start <= act && is_tx && tx_pending[message_number_field[TXBUF_W-1:0]];
			if (act && is_tx) begin
				tx_buf <= message_number_field[TXBUF_W-1:0];
				tx_arbitrating <= (ty == TY_TX_ARB) || (ty == TY_TX_MERGED);
			end
			watch_fired <= act && ((ty == TY_WATCH) || (ty == TY_WATCH_GAP));
			event_int <= act && (ty == TY_TIMEBASE) && elem_q[INTERNAL_EVENT_ENABLE_BIT];
			event_ext <= act && (ty == TY_TIMEBASE) && elem_q[EXTERNAL_EVENT_ENABLE_BIT];
			event_asc <= act && (ty == TY_TIMEBASE) && elem_q[ASC_BIT];
			if (ref_msg_ok) begin
				prev_merged_q <= 1'b0;
			end else if (act && is_tx) begin
				prev_merged_q <= ty == TY_TX_MERGED;
			end
		end
	end

	// Reference request held until the next sample point
	always_ff @(posedge clock) begin
		if (srst) begin
			ref_req_q <= 1'b0;
			ref_tx_start <= 1'b0;
		end else begin
			ref_tx_start <= ref_req_q && bit_sample;
			if (act && is_ref) begin
				ref_req_q <= 1'b1;
			end else if (bit_sample) begin
				ref_req_q <= 1'b0;
			end
		end
	end

	// Last accepted frame since cycle start or previous check
	always_ff @(posedge clock) begin
		if (srst) begin
			last_rx_valid_q <= 1'b0;
			last_rx_filter_q <= '0;
			rx_check <= 1'b0;
			rx_check_ok <= 1'b0;
			rx_filter_kind <= 1'b0;
		end else begin
			rx_check <= act && (ty == TY_RX);
			if (act && (ty == TY_RX)) begin
				rx_check_ok <= last_rx_valid_q && (last_rx_filter_q == message_number_field);
				rx_filter_kind <= elem_q[FKIND_BIT];
			end
			if (rx_accept) begin
				last_rx_valid_q <= 1'b1;
				last_rx_filter_q <= rx_accept_filter;
			end else if (ref_msg_ok || (act && (ty == TY_RX))) begin
				last_rx_valid_q <= 1'b0;
			end
		end
	end

	// Pending clear only for single-shot sends
	always_ff @(posedge clock) begin
		if (srst) begin
			active_single_q <= 1'b0;
			active_buf_q <= '0;
			tx_clear_pending <= 1'b0;
			tx_clear_buf <= '0;
		end else begin
			if (act && is_tx && tx_pending[message_number_field[TXBUF_W-1:0]]) begin
				active_single_q <= ty == TY_TX_SINGLE;
				active_buf_q <= message_number_field[TXBUF_W-1:0];
			end
			tx_clear_pending <= tx_done && active_single_q;
			if (tx_done) tx_clear_buf <= active_buf_q;
		end
	end

	assign cycle_time = cycle_time_q;
	assign sync_mark = sync_mark_q;
	assign ref_mark = ref_mark_q;
	assign ref_tx_req = ref_req_q;
	assign config_error = cfg_err_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	chk_prep_on_step: assert property (
		tx_prep |-> state_q == ST_WAIT && $past(state_q) == ST_EVAL)
		else $error("tx prepare without step to transmit trigger");
	chk_ref_at_sample: assert property (
		ref_tx_start |-> $past(ref_req_q) && $past(bit_sample))
		else $error("reference start off sample point");
	chk_ref_mark_take: assert property (
		ref_msg_ok |=> ref_mark_q == $past(sync_mark_q))
		else $error("reference mark not taken from sync mark");
	chk_sof_keeps_count: assert property (
		sof_sample && !ref_msg_ok && ntu_tick |=> cycle_time_q == $past(cycle_time_q) + 16'h0001)
		else $error("cycle time stopped at start of frame");
	chk_slave_ref_error: assert property (
		state_q == ST_EVAL && is_ref && !time_master && !ref_msg_ok |=> cfg_err_q
		##1 error_level_field == EL_SEV3)
		else $error("slave reference trigger not flagged");
	chk_list_end_halt: assert property (
		state_q == ST_EVAL && ty > TY_TIMEBASE && !ref_msg_ok |=> state_q == ST_HALT && cfg_err_q)
		else $error("list end did not halt engine");
	chk_short_mark_err: assert property (
		state_q == ST_EVAL && eval_use && tm < ref_msg_len && !ref_msg_ok |=> cfg_err_q)
		else $error("short time mark accepted");
	chk_single_clear: assert property (
		tx_done && active_single_q |=> tx_clear_pending)
		else $error("single send did not clear pending");
	chk_cont_keeps: assert property (
		tx_done && !active_single_q |=> !tx_clear_pending)
		else $error("continuous send cleared pending");
	chk_merged_seq: assert property (
		state_q == ST_EVAL && prev_merged_q && cc.match && (ty == TY_TX_SINGLE || ty == TY_TX_CONT)
		&& !ref_msg_ok |=> state_q == ST_HALT)
		else $error("merged window closed by wrong trigger");
	chk_scan_restart: assert property (
		ref_msg_ok && state_q != ST_HALT |=> state_q == ST_FETCH && idx_q == IDX_FIRST
		##1 state_q == ST_EVAL)
		else $error("scan did not restart at first element");
	chk_advance_mark: assert property (
		act && !terminal && idx_q != IDX_LAST && !ref_msg_ok |=> state_q == ST_FETCH
		&& idx_q == $past(idx_q) + 6'h01)
		else $error("engine did not advance at time mark");

	cov_tx_send: cover property (tx_start ##[1:1000] tx_clear_pending);
	cov_ref_sent: cover property (ref_tx_req ##[1:50] ref_tx_start);
	cov_rx_ok: cover property (rx_check && rx_check_ok);
	cov_watch: cover property (watch_fired);
endmodule : ttse_engine

// ==== ttse_pkg.sv ====
package ttse_pkg;
	// ---------------------------------------------------------------
	// Element layout
	// ---------------------------------------------------------------
	localparam int ELEM_W = 41;
	localparam int TM_W = 16;
	localparam int TM_LSB = 0;
	localparam int CC_W = 7;
	localparam int CC_LSB = 16;
	localparam int TYPE_LSB = 23;
	localparam int FKIND_BIT = 27;
	localparam int MNR_LSB = 28;
	localparam int MNR_W = 7;
	localparam int MSC_LSB = 35;
	localparam int INTERNAL_EVENT_ENABLE_BIT = 38;
	localparam int EXTERNAL_EVENT_ENABLE_BIT = 39;
	localparam int ASC_BIT = 40;
	localparam int TRIG_DEPTH = 64;
	localparam int IDX_W = 6;
	localparam int CNT_W = 6;
	localparam int TXBUF_W = 5;
	localparam int IRTO_W = 7;
	// ---------------------------------------------------------------
	// Trigger types, states, offsets and reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] TY_REF = 4'h0;
	localparam logic [3:0] TY_REF_GAP = 4'h1;
	localparam logic [3:0] TY_TX_SINGLE = 4'h2;
	localparam logic [3:0] TY_TX_CONT = 4'h3;
	localparam logic [3:0] TY_TX_ARB = 4'h4;
	localparam logic [3:0] TY_TX_MERGED = 4'h5;
	localparam logic [3:0] TY_WATCH = 4'h6;
	localparam logic [3:0] TY_WATCH_GAP = 4'h7;
	localparam logic [3:0] TY_RX = 4'h8;
	localparam logic [3:0] TY_TIMEBASE = 4'h9;
	localparam logic [1:0] SYS_IN_GAP = 2'h2;
	localparam logic [1:0] SYS_IN_SCHED = 2'h3;
	localparam logic [1:0] EL_SEV2 = 2'h2;
	localparam logic [1:0] EL_SEV3 = 2'h3;
	localparam logic [15:0] REF_SEV2_OFFSET = 16'h0127;
	localparam logic [15:0] TIME_RST = 16'h0000;
	localparam logic [IDX_W-1:0] IDX_FIRST = 6'h00;
	localparam logic [IDX_W-1:0] IDX_LAST = 6'h3f;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_FETCH = 5'h02,
		ST_EVAL = 5'h04,
		ST_WAIT = 5'h08,
		ST_HALT = 5'h10
	} ttse_state_t;
endpackage : ttse_pkg
